//--- ttc_defines.vh
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH
// time base divisors
`define TTC_DIV_SLOW 4'hc
`define TTC_DIV_FAST 4'h6
// timer mode register fields
`define TTC_TM0_MODE_LO 0
`define TTC_TM0_MODE_HI 1
`define TTC_TM0_CT 2
`define TTC_TM0_GATE 3
`define TTC_TM1_MODE_LO 4
`define TTC_TM1_MODE_HI 5
`define TTC_TM1_CT 6
`define TTC_TM1_GATE 7
// modes
`define TTC_MODE_13 2'h0
`define TTC_MODE_16 2'h1
`define TTC_MODE_RLD 2'h2
`define TTC_MODE_SPLIT 2'h3
// mode 0 low byte width
`define TTC_M0_LOW_MAX 5'h1f
`define TTC_BYTE_MAX 8'hff
`define TTC_T2_MAX 16'hffff
`endif

//--- ttc_tick.v
`timescale 1ns/10ps
`default_nettype none
`include "ttc_defines.vh"
// time-base prescaler: one pulse every 12 or 6 clocks
module ttc_tick (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire fast_i,
  output wire tick_o
);
  reg [3:0] cnt_ff;
  wire [3:0] lim;
  assign lim = fast_i ? `TTC_DIV_FAST : `TTC_DIV_SLOW;
  assign tick_o = (cnt_ff >= lim - 4'h1);
  // restart on terminal count; a switch to fast mid-period ends early
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_ff <= 4'h0;
    else if (tick_o)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= cnt_ff + 4'h1;
  end
endmodule
`default_nettype wire

//--- ttc_top.v
`timescale 1ns/10ps
`default_nettype none
`include "ttc_defines.vh"
module ttc_top (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire [7:0] timer_mode_register_i,
  input wire run_bit0_i,
  input wire run_bit1_i,
  input wire speed_bit_timer_zero_i,
  input wire speed_bit_timer_one_i,
  input wire speed_bit_timer_two_i,
  input wire option_twelve_clk_i,
  input wire run_bit2_i,
  input wire timer_two_counter_select_i,
  input wire capture_select_i,
  input wire trigger_enable_i,
  input wire gate_input_pin0_i,
  input wire gate_input_pin1_i,
  input wire count_pin_zero_i,
  input wire count_pin_one_i,
  input wire count_pin_two_i,
  input wire trigger_pin_i,
  input wire clr_overflow_flag0_i,
  input wire clr_overflow_flag1_i,
  input wire clr_timer_two_overflow_flag_i,
  input wire clr_trigger_flag_i,
  input wire wr_count_low_byte0_i,
  input wire wr_count_high_byte0_i,
  input wire wr_count_low_byte1_i,
  input wire wr_count_high_byte1_i,
  input wire wr_timer_two_low_byte_i,
  input wire wr_timer_two_high_byte_i,
  input wire [7:0] wr_data_i,
  output wire [7:0] count_low_byte0_o,
  output wire [7:0] count_high_byte0_o,
  output wire [7:0] count_low_byte1_o,
  output wire [7:0] count_high_byte1_o,
  output wire [7:0] timer_two_low_byte_o,
  output wire [7:0] timer_two_high_byte_o,
  output wire [7:0] capture_low_byte_o,
  output wire [7:0] capture_high_byte_o,
  output wire overflow_flag0_o,
  output wire overflow_flag1_o,
  output wire timer_two_overflow_flag_o,
  output wire trigger_flag_o
);
  // count, capture and flag registers
  reg [7:0] tl0_ff;
  reg [7:0] th0_ff;
  reg [7:0] tl1_ff;
  reg [7:0] th1_ff;
  reg [7:0] tl2_ff;
  reg [7:0] th2_ff;
  reg [7:0] cap_lo_ff;
  reg [7:0] cap_hi_ff;
  reg of0_ff;
  reg of1_ff;
  reg of2_ff;
  reg trig_flag_ff;
  reg [3:0] pin_d_ff;
  // next values from the combinational blocks
  reg [7:0] nxt_tl0;
  reg [7:0] nxt_th0;
  reg [7:0] nxt_tl1;
  reg [7:0] nxt_th1;
  reg set_of0;
  reg set_of1;
  wire [2:0] tick;
  wire [2:0] speed;
  wire [3:0] pins;
  wire [3:0] fall;
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire ct0;
  wire ct1;
  wire en0;
  wire en1;
  wire inc0;
  wire inc1;
  wire inc0_hi;
  wire inc2;
  wire [15:0] t2_sum;
  wire t2_wrap;
  wire capture;
  wire split0;
  // decode one timer's mode field
  function [1:0] mode_of;
    input [7:0] tm;
    input hi_half;
    begin
      mode_of = hi_half ? {tm[`TTC_TM1_MODE_HI], tm[`TTC_TM1_MODE_LO]}
                        : {tm[`TTC_TM0_MODE_HI], tm[`TTC_TM0_MODE_LO]};
    end
  endfunction
  assign speed = option_twelve_clk_i ? 3'h0
               : {speed_bit_timer_two_i, speed_bit_timer_one_i, speed_bit_timer_zero_i};
  // per-timer time base
  // one prescaler per timer, so each speed bit acts on its own timer only
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_tick
      ttc_tick i_ttc_tick (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .fast_i(speed[g]),
        .tick_o(tick[g])
      );
    end
  endgenerate
  // external pins are synchronous; remember last level for falling edges
  // history resets low, so a pin held high through reset cannot fake an edge
  assign pins = {trigger_pin_i, count_pin_two_i, count_pin_one_i, count_pin_zero_i};
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pin_d_ff <= 4'h0;
    else
      pin_d_ff <= pins;
  end
  // falling edge: high last cycle, low now
  assign fall = pin_d_ff & ~pins;
  assign mode0 = mode_of(timer_mode_register_i, 1'b0);
  assign mode1 = mode_of(timer_mode_register_i, 1'b1);
  assign ct0 = timer_mode_register_i[`TTC_TM0_CT];
  assign ct1 = timer_mode_register_i[`TTC_TM1_CT];
  // timer zero split decides who owns timer one's run bit and flag
  assign split0 = (mode0 == `TTC_MODE_SPLIT);
  assign en0 = run_bit0_i & (~timer_mode_register_i[`TTC_TM0_GATE] | gate_input_pin0_i);
  // timer one keeps its gate but loses run bit to timer zero high byte
  assign en1 = (split0 ? 1'b1 : run_bit1_i)
             & (~timer_mode_register_i[`TTC_TM1_GATE] | gate_input_pin1_i);
  assign inc0 = en0 & (ct0 ? fall[0] : tick[0]);
  assign inc1 = en1 & (mode1 != `TTC_MODE_SPLIT) & (ct1 ? fall[1] : tick[1]);
  // split high byte counts time base under timer one run bit
  assign inc0_hi = split0 & run_bit1_i & tick[0];
  // timer zero next state per mode
  always @*
  begin
    nxt_tl0 = tl0_ff;
    nxt_th0 = th0_ff;
    set_of0 = 1'b0;
    set_of1 = 1'b0;
    if (inc0)
    begin
      case (mode0)
        // thirteen-bit count, upper low bits ignored
        `TTC_MODE_13:
        begin
          nxt_tl0 = {tl0_ff[7:5], tl0_ff[4:0] + 5'h01};
          if (tl0_ff[4:0] == `TTC_M0_LOW_MAX)
          begin
            nxt_th0 = th0_ff + 8'h01;
            set_of0 = (th0_ff == `TTC_BYTE_MAX);
          end
        end
        `TTC_MODE_16:
        begin
          nxt_tl0 = tl0_ff + 8'h01;
          if (tl0_ff == `TTC_BYTE_MAX)
          begin
            nxt_th0 = th0_ff + 8'h01;
            set_of0 = (th0_ff == `TTC_BYTE_MAX);
          end
        end
        `TTC_MODE_RLD:
        begin
          nxt_tl0 = (tl0_ff == `TTC_BYTE_MAX) ? th0_ff : tl0_ff + 8'h01;
          set_of0 = (tl0_ff == `TTC_BYTE_MAX);
        end
        // split low byte uses timer zero flag
        default:
        begin
          nxt_tl0 = tl0_ff + 8'h01;
          set_of0 = (tl0_ff == `TTC_BYTE_MAX);
        end
      endcase
    end
    // split high byte raises timer one flag
    if (inc0_hi)
    begin
      nxt_th0 = th0_ff + 8'h01;
      set_of1 = (th0_ff == `TTC_BYTE_MAX);
    end
  end
  // timer one next state; its flag is lost while timer zero is split
  reg set_of1_own;
  always @*
  begin
    nxt_tl1 = tl1_ff;
    nxt_th1 = th1_ff;
    set_of1_own = 1'b0;
    if (inc1)
    begin
      case (mode1)
        `TTC_MODE_13:
        begin
          nxt_tl1 = {tl1_ff[7:5], tl1_ff[4:0] + 5'h01};
          if (tl1_ff[4:0] == `TTC_M0_LOW_MAX)
          begin
            nxt_th1 = th1_ff + 8'h01;
            set_of1_own = (th1_ff == `TTC_BYTE_MAX);
          end
        end
        `TTC_MODE_16:
        begin
          nxt_tl1 = tl1_ff + 8'h01;
          if (tl1_ff == `TTC_BYTE_MAX)
          begin
            nxt_th1 = th1_ff + 8'h01;
            set_of1_own = (th1_ff == `TTC_BYTE_MAX);
          end
        end
        `TTC_MODE_RLD:
        begin
          nxt_tl1 = (tl1_ff == `TTC_BYTE_MAX) ? th1_ff : tl1_ff + 8'h01;
          set_of1_own = (tl1_ff == `TTC_BYTE_MAX);
        end
        default:
        begin
          nxt_tl1 = tl1_ff;
        end
      endcase
    end
  end
  // count registers; a software write wins over counting in the same cycle
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tl0_ff <= 8'h00;
      th0_ff <= 8'h00;
      tl1_ff <= 8'h00;
      th1_ff <= 8'h00;
    end
    else
    begin
      tl0_ff <= wr_count_low_byte0_i ? wr_data_i : nxt_tl0;
      th0_ff <= wr_count_high_byte0_i ? wr_data_i : nxt_th0;
      tl1_ff <= wr_count_low_byte1_i ? wr_data_i : nxt_tl1;
      th1_ff <= wr_count_high_byte1_i ? wr_data_i : nxt_th1;
    end
  end
  assign inc2 = run_bit2_i & (timer_two_counter_select_i ? fall[2] : tick[2]);
  assign t2_sum = {th2_ff, tl2_ff} + 16'h0001;
  // capture-mode wrap
  // a byte write in the wrap cycle still raises the flag: the count did wrap
  assign t2_wrap = inc2 & capture_select_i & ({th2_ff, tl2_ff} == `TTC_T2_MAX);
  assign capture = capture_select_i & trigger_enable_i & fall[3];
  // timer two counts only in capture mode; other modes are not built here
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tl2_ff <= 8'h00;
      th2_ff <= 8'h00;
      cap_lo_ff <= 8'h00;
      cap_hi_ff <= 8'h00;
    end
    else
    begin
      // a write beats counting, as for timers zero and one
      if (wr_timer_two_low_byte_i)
        tl2_ff <= wr_data_i;
      else if (inc2 & capture_select_i)
        tl2_ff <= t2_sum[7:0];
      if (wr_timer_two_high_byte_i)
        th2_ff <= wr_data_i;
      else if (inc2 & capture_select_i)
        th2_ff <= t2_sum[15:8];
      if (capture)
      begin
        cap_lo_ff <= tl2_ff;
        cap_hi_ff <= th2_ff;
      end
    end
  end
  // sticky flags; a set in the clear cycle wins
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      of0_ff <= 1'b0;
      of1_ff <= 1'b0;
      of2_ff <= 1'b0;
      trig_flag_ff <= 1'b0;
    end
    else
    begin
      of0_ff <= set_of0 | (of0_ff & ~clr_overflow_flag0_i);
      // timer one flag owned by split high byte when timer zero is in mode 3
      of1_ff <= (split0 ? set_of1 : set_of1_own)
              | (of1_ff & ~clr_overflow_flag1_i);
      of2_ff <= t2_wrap | (of2_ff & ~clr_timer_two_overflow_flag_i);
      trig_flag_ff <= capture | (trig_flag_ff & ~clr_trigger_flag_i);
    end
  end
  // outputs come straight from registers
  assign count_low_byte0_o = tl0_ff;
  assign count_high_byte0_o = th0_ff;
  assign count_low_byte1_o = tl1_ff;
  assign count_high_byte1_o = th1_ff;
  assign timer_two_low_byte_o = tl2_ff;
  assign timer_two_high_byte_o = th2_ff;
  assign capture_low_byte_o = cap_lo_ff;
  assign capture_high_byte_o = cap_hi_ff;
  assign overflow_flag0_o = of0_ff;
  assign overflow_flag1_o = of1_ff;
  assign timer_two_overflow_flag_o = of2_ff;
  assign trigger_flag_o = trig_flag_ff;
endmodule
`default_nettype wire

//--- ttc_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: count pins idle high, gates low, trigger idle high
module ttc_pins_model (
  input wire logic ref_clk_i,
  output logic [2:0] cnt_pin_o,
  output logic [1:0] gate_pin_o,
  output logic trig_pin_o
);
  initial
  begin
    cnt_pin_o = 3'h7;
    gate_pin_o = 2'h0;
    trig_pin_o = 1'b1;
  end
  task pulse(input int n);
    repeat (n)
    begin
      @(negedge ref_clk_i) cnt_pin_o = 3'h0;
      @(negedge ref_clk_i) cnt_pin_o = 3'h7;
    end
  endtask
  // one low cycle on the trigger
  task trig();
    @(negedge ref_clk_i) trig_pin_o = 1'b0;
    @(negedge ref_clk_i) trig_pin_o = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- ttc_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ttc_top_chk (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] timer_mode_register_i,
  input wire logic run_bit0_i,
  input wire logic option_twelve_clk_i,
  input wire logic capture_select_i,
  input wire logic trigger_enable_i,
  input wire logic trigger_pin_i,
  input wire logic clr_overflow_flag0_i,
  input wire logic clr_trigger_flag_i,
  input wire logic wr_count_low_byte0_i,
  input wire logic wr_count_high_byte0_i,
  input wire logic [7:0] count_low_byte0_o,
  input wire logic [7:0] count_high_byte0_o,
  input wire logic overflow_flag0_o,
  input wire logic trigger_flag_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // byte writes win over counting, so they mask the checks
  wire nowr = !wr_count_low_byte0_i && !wr_count_high_byte0_i;
  wire [1:0] md = timer_mode_register_i[1:0];
  wire [12:0] c13 = {count_high_byte0_o, count_low_byte0_o[4:0]};
  wire [7:0] lo = count_low_byte0_o;
  sequence s_hold8;
    $stable(lo)[*8];
  endsequence
  AST_STOP0: assert property (!run_bit0_i && nowr |=> $stable(lo))
    else $error("low byte moved while stopped");
  AST_RATE12: assert property ($changed(lo) && option_twelve_clk_i &&
    !timer_mode_register_i[2] && $past(nowr) |=> s_hold8)
    else $error("count rate faster than twelve clocks");
  AST_M0_WRAP: assert property (md == 2'h0 && c13 == 13'h1fff && nowr |=>
    $stable(lo[7:5]) && (c13 == 13'h1fff || (c13 == 13'h0 && overflow_flag0_o)))
    else $error("thirteen bit wrap wrong");
  AST_M2_RELOAD: assert property (md == 2'h2 && lo == 8'hff && nowr |=>
    lo == 8'hff || (lo == $past(count_high_byte0_o) && overflow_flag0_o))
    else $error("reload from high byte wrong");
  AST_FLAG_AT_WRAP: assert property ($rose(overflow_flag0_o) && md != 2'h2 |->
    lo[4:0] == 5'h0)
    else $error("flag rose without wrap");
  AST_TRIG_FLAG: assert property (capture_select_i && trigger_enable_i &&
    $fell(trigger_pin_i) |=> trigger_flag_o)
    else $error("trigger flag missing");
  AST_FLAG0_HOLD: assert property (overflow_flag0_o && !clr_overflow_flag0_i |=>
    overflow_flag0_o)
    else $error("overflow flag dropped");
  AST_TRIG_CLEAR: assert property ($fell(trigger_flag_o) |-> $past(clr_trigger_flag_i))
    else $error("trigger flag dropped");
endmodule
bind ttc_top ttc_top_chk i_ttc_top_chk (.*);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] tm = 8'h0;
  logic [2:0] run = 3'h0;
  logic [2:0] spd = 3'h0;
  logic opt = 1'b0;
  logic ct2 = 1'b0;
  logic cap = 1'b0;
  logic ten = 1'b0;
  logic [3:0] clr = 4'h0;
  logic [5:0] wr = 6'h0;
  logic [7:0] wd = 8'h0;
  wire [2:0] cp;
  wire [1:0] gp;
  wire tp;
  wire [63:0] q;
  wire [3:0] f;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  ttc_pins_model i_ttc_pins_model (.ref_clk_i(ref_clk_i), .cnt_pin_o(cp), .gate_pin_o(gp),
    .trig_pin_o(tp));
  ttc_top i_ttc_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .timer_mode_register_i(tm),
    .run_bit0_i(run[0]), .run_bit1_i(run[1]), .run_bit2_i(run[2]),
    .speed_bit_timer_zero_i(spd[0]), .speed_bit_timer_one_i(spd[1]),
    .speed_bit_timer_two_i(spd[2]), .option_twelve_clk_i(opt),
    .timer_two_counter_select_i(ct2), .capture_select_i(cap), .trigger_enable_i(ten),
    .gate_input_pin0_i(gp[0]), .gate_input_pin1_i(gp[1]), .count_pin_zero_i(cp[0]),
    .count_pin_one_i(cp[1]), .count_pin_two_i(cp[2]), .trigger_pin_i(tp),
    .clr_overflow_flag0_i(clr[0]), .clr_overflow_flag1_i(clr[1]),
    .clr_timer_two_overflow_flag_i(clr[2]), .clr_trigger_flag_i(clr[3]),
    .wr_count_low_byte0_i(wr[0]), .wr_count_high_byte0_i(wr[1]),
    .wr_count_low_byte1_i(wr[2]), .wr_count_high_byte1_i(wr[3]),
    .wr_timer_two_low_byte_i(wr[4]), .wr_timer_two_high_byte_i(wr[5]), .wr_data_i(wd),
    .count_low_byte0_o(q[7:0]), .count_high_byte0_o(q[15:8]),
    .count_low_byte1_o(q[23:16]), .count_high_byte1_o(q[31:24]),
    .timer_two_low_byte_o(q[39:32]), .timer_two_high_byte_o(q[47:40]),
    .capture_low_byte_o(q[55:48]), .capture_high_byte_o(q[63:56]),
    .overflow_flag0_o(f[0]), .overflow_flag1_o(f[1]),
    .timer_two_overflow_flag_o(f[2]), .trigger_flag_o(f[3]));
  task summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // reset with the set-up applied, so the prescaler phase is known
  task restart();
    @(negedge ref_clk_i) rstn_i = 1'b0;
    cyc(8);
    rstn_i = 1'b1;
  endtask
  task wrt(input logic [5:0] s, input logic [7:0] d);
    wr = s;
    wd = d;
    cyc(1);
    wr = 6'h0;
  endtask
  task sc_rate();
    tm = 8'h01;
    run = 3'h7;
    cap = 1'b1;
    restart();
    cyc(120);
    chk(q[15:0], 16'h000a);
    chk(q[31:16], 16'h000a);
    chk(q[47:32], 16'h000a);
    spd = 3'h7;
    restart();
    cyc(60);
    chk(q[15:0], 16'h000a);
    chk(q[31:16], 16'h000a);
    chk(q[47:32], 16'h000a);
    opt = 1'b1;
    restart();
    cyc(60);
    chk(q[15:0], 16'h0005);
    chk(q[31:16], 16'h0005);
    chk(q[47:32], 16'h0005);
    opt = 1'b0;
    spd = 3'h0;
  endtask
  task sc_gate();
    tm = 8'hdd;
    cap = 1'b1;
    ct2 = 1'b1;
    restart();
    i_ttc_pins_model.pulse(3);
    cyc(2);
    chk({q[23:16], q[7:0]}, 16'h0000);
    chk({8'h0, q[39:32]}, 16'h0003);
    i_ttc_pins_model.gate_pin_o = 2'h3;
    i_ttc_pins_model.pulse(4);
    cyc(2);
    chk({q[23:16], q[7:0]}, 16'h0404);
    run = 3'h0;
    i_ttc_pins_model.pulse(2);
    cyc(2);
    chk({q[39:32], q[7:0]}, 16'h0704);
    i_ttc_pins_model.gate_pin_o = 2'h0;
    cap = 1'b0;
    ct2 = 1'b0;
  endtask
  task sc_wrap();
    tm = 8'h00;
    run = 3'h1;
    restart();
    wrt(6'h03, 8'hff);
    cyc(11);
    chk(q[15:0], 16'h00e0);
    cyc(30);
    chk({12'h0, f}, 16'h0001);
    clr = 4'hf;
    cyc(1);
    clr = 4'h0;
    chk({12'h0, f}, 16'h0000);
    tm = 8'h01;
    wrt(6'h03, 8'hff);
    cyc(24);
    chk(q[15:0], 16'h0001);
    chk({12'h0, f}, 16'h0001);
    tm = 8'h22;
    run = 3'h3;
    restart();
    wrt(6'h05, 8'hfe);
    cyc(1);
    wrt(6'h0a, 8'h40);
    cyc(22);
    chk({q[15:0]}, 16'h4040);
    chk(q[31:16], 16'h4040);
    chk({12'h0, f}, 16'h0003);
  endtask
  task sc_split();
    tm = 8'h13;
    run = 3'h3;
    restart();
    wrt(6'h06, 8'hff);
    cyc(23);
    chk(q[15:0], 16'h0102);
    chk({q[23:16], 4'h0, f}, 16'h0102);
    chk(q[31:16], 16'h0101);
    tm = 8'h30;
    cyc(24);
    chk(q[31:16], 16'h0101);
    tm = 8'h13;
    run = 3'h1;
    cyc(12);
    chk({q[23:16], q[15:8]}, 16'h0201);
  endtask
  task sc_capture();
    tm = 8'h00;
    run = 3'h4;
    cap = 1'b1;
    ten = 1'b1;
    restart();
    wrt(6'h30, 8'hff);
    cyc(11);
    chk({q[47:32]}, 16'h0000);
    chk({12'h0, f}, 16'h0004);
    cyc(14);
    i_ttc_pins_model.trig();
    cyc(1);
    chk(q[63:48], 16'h0001);
    chk({12'h0, f}, 16'h000c);
    clr = 4'hc;
    cyc(1);
    clr = 4'h0;
    chk({12'h0, f}, 16'h0000);
  endtask
  initial
  begin
    sc_rate();
    sc_gate();
    sc_wrap();
    sc_split();
    sc_capture();
    summarize();
  end
endmodule
`default_nettype wire
